//--- include/sstat_pkg.sv
// Purpose: constants shared by the stepper status reporting block
// Assumes: 16-bit input words, 50 MHz core clock
// Notes:   word indices follow the command mode input data order
package sstat_pkg;
    localparam int          SSTAT_WORD_W      = 16;
    localparam int          SSTAT_NUM_WORDS   = 10;
    // word indices of the input data image
    localparam logic [3:0]  SSTAT_IDX_MOTION  = 4'h0;
    localparam logic [3:0]  SSTAT_IDX_DRIVE   = 4'h1;
    localparam logic [3:0]  SSTAT_IDX_MPOS_HI = 4'h2;
    localparam logic [3:0]  SSTAT_IDX_MPOS_LO = 4'h3;
    localparam logic [3:0]  SSTAT_IDX_EPOS_HI = 4'h4;
    localparam logic [3:0]  SSTAT_IDX_EPOS_LO = 4'h5;
    localparam logic [3:0]  SSTAT_IDX_CPOS_HI = 4'h6;
    localparam logic [3:0]  SSTAT_IDX_CPOS_LO = 4'h7;
    localparam logic [3:0]  SSTAT_IDX_CURR    = 4'h8;
    localparam logic [3:0]  SSTAT_IDX_JERK    = 4'h9;
    // multi-word format: value = hi * 1000 + lo, both parts share the sign
    localparam logic signed [31:0] SSTAT_POS_SCALE = 32'sh0000_03e8;
    // motor current limits in tenths of an amp
    localparam logic [15:0] SSTAT_CURR_MIN    = 16'h000a;
    localparam logic [15:0] SSTAT_CURR_MAX    = 16'h003c;
    localparam logic [15:0] SSTAT_CURR_RESET  = 16'h000a;
    // heartbeat timing
    localparam int          SSTAT_CLK_HZ      = 50000000;
    localparam int          SSTAT_BEAT_MS     = 500;
    localparam int          SSTAT_BEAT_CYC    = SSTAT_CLK_HZ / 1000 * SSTAT_BEAT_MS;
    localparam logic [7:0]  SSTAT_MSEG_FIRST  = 8'h08;

    // motion state of the axis as seen by the status block
    typedef enum logic [2:0] {
        SSTAT_ST_IDLE  = 3'b000,
        SSTAT_ST_ACCEL = 3'b001,
        SSTAT_ST_RUN   = 3'b010,
        SSTAT_ST_DECEL = 3'b011,
        SSTAT_ST_HOLD  = 3'b100
    } sstat_motion_t;
endpackage

//--- core/sstat_status.sv
// Purpose: status word builder and input data image of a stepper indexer
// Assumes: event inputs are one-cycle pulses, levels synchronous to core_clk
// Notes:   the host reads word_data at word_idx; positions are sampled as pairs
//
// What this block does
// - ten input words: two status, three position pairs, current, jerk
// - status bit 15 shows configuration mode; power up in command mode
// - setup_fault set until valid configuration; stall enable in config mode
// - order_fault set by invalid command, cleared only by error clear
// - out of range current is ignored without error, old value kept
// - input_fault set by estop, limits, manual into limit, homing overrun
// - position_untrusted set by config, no home, link loss, stops, limits, stall
// - absolute moves refused while position untrusted
// - segment_request and profile_load flag readiness; host waits for segment_request
// - move_done set on clean finish, cleared by move, preset or clear
// - move_done set with order_fault on bad manual or registration params
// - slowing, speeding flags follow profile; origin_found after good homing
// - halted_flag whenever motor not moving
// - paused_flag in hold state; direction flags follow rotation
// - drive_on shows current available; off on fault or zero idle current
// - stall, output one level shown; reserved bits read zero
// - alive_toggle inverts every 500 ms in command mode
// - limit_hit set at limit in move, cleared on release or error clear
// - bad_param_change on invalid manual changes or gearing out of range
// - follow_lag when hybrid control lags more than one turn
// - power_stage_fault on driver faults, not jumper at power up
// - link_dropped with input_fault when physical link restored
// - neither word of a negative position is positive; the upper word is zero above -1000
`timescale 1ns/1ps
module sstat_status
    import sstat_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // mode and configuration
    input  wire logic        config_mode,
    input  wire logic        config_write,
    input  wire logic        config_valid,
    input  wire logic        stall_detect_en,
    input  wire logic        controller_healthy,
    // command events
    input  wire logic        cmd_invalid,
    input  wire logic        cmd_param_range_err,
    input  wire logic        cmd_move,
    input  wire logic        cmd_absolute,
    input  wire logic        cmd_manual,
    input  wire logic        cmd_manual_dir_ccw,
    input  wire logic        cmd_home,
    input  wire logic        cmd_preset,
    input  wire logic        cmd_stop_now,
    input  wire logic        cmd_error_clear,
    input  wire logic        cmd_fault_clear,
    input  wire logic        cmd_current_wr,
    input  wire logic [15:0] cmd_current,
    input  wire logic [15:0] jerk_value,
    // motion engine
    input  wire logic        motion_accel,
    input  wire logic        motion_decel,
    input  wire logic        motion_moving,
    input  wire logic        motion_hold,
    input  wire logic        motion_ccw,
    input  wire logic        motion_done,
    input  wire logic        motion_homing,
    input  wire logic        home_done,
    input  wire logic        segment_request,
    input  wire logic        profile_load,
    // field signals
    input  wire logic        estop_active,
    input  wire logic        limit_cw,
    input  wire logic        limit_ccw,
    input  wire logic        stall_seen,
    input  wire logic        output_one_level,
    input  wire logic        driver_enable,
    input  wire logic        idle_to_zero,
    input  wire logic        drv_over_temp,
    input  wire logic        drv_short,
    input  wire logic        drv_no_jumper,
    input  wire logic        manual_param_bad,
    input  wire logic [7:0]  gear_num,
    input  wire logic [7:0]  gear_den,
    input  wire logic        gear_active,
    input  wire logic        hybrid_on,
    input  wire logic [31:0] lag_steps,
    input  wire logic [31:0] steps_per_turn,
    input  wire logic        link_restored,
    input  wire logic        host_program_mode,
    // positions
    input  wire logic signed [31:0] motor_pos,
    input  wire logic signed [31:0] encoder_pos,
    input  wire logic signed [31:0] capture_pos,
    input  wire logic        sample_strobe,
    // host read port
    input  wire logic [3:0]  word_idx,
    output logic [15:0]      word_data,
    output logic             abs_move_refused,
    output logic             motor_current_on,
    output logic [15:0]      current_in_use
);
    // reset release through two flops
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rst_ok_n = rst_s2_reg;

    // split into multi-word format; truncating division keeps both signs equal
    function automatic logic [31:0] sstat_split(input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = v / SSTAT_POS_SCALE;
        lo = v - hi * SSTAT_POS_SCALE;
        return {hi[15:0], lo[15:0]};
    endfunction

    // sticky flags of the first status word
    logic        setup_fault_reg;
    logic        order_fault_reg;
    logic        input_fault_reg;
    logic        untrusted_reg;
    logic        move_done_reg;
    logic        origin_found_reg;

    // sticky flags of the second status word
    logic        limit_hit_reg;
    logic        bad_param_reg;
    logic        power_fault_reg;
    logic        link_dropped_reg;
    logic        alive_reg;
    logic        seen_enable_reg;

    // held values, sampled positions and limit history
    logic [15:0] current_reg;
    logic [31:0] beat_cnt_reg;
    logic [31:0] mpos_reg;
    logic [31:0] epos_reg;
    logic [31:0] cpos_reg;
    logic        limit_cw_d_reg;
    logic        limit_ccw_d_reg;

    // event decode
    wire limit_any     = limit_cw | limit_ccw;
    wire limit_in_move = motion_moving & limit_any;
    wire limit_set     = limit_in_move & ~motion_homing;
    wire manual_into   = cmd_manual & (cmd_manual_dir_ccw ? limit_ccw : limit_cw);
    // any limit met while homing is taken as the far one
    wire home_overrun  = motion_homing & limit_any;
    wire input_set     = estop_active | limit_set | manual_into | home_overrun
                         | link_restored;
    wire limit_release = (limit_cw_d_reg & ~limit_cw) | (limit_ccw_d_reg & ~limit_ccw);
    wire untrust_set   = config_write | link_restored | cmd_stop_now | estop_active
                         | limit_in_move | stall_seen;
    // 8-bit gearing terms can only leave 1 to 255 by being zero
    wire gear_bad      = gear_active & ((gear_num == 8'h00) | (gear_den == 8'h00));
    wire param_set     = (cmd_manual & manual_param_bad) | gear_bad;
    wire drv_fault_now = driver_enable & (drv_over_temp | drv_short
                         | (drv_no_jumper & seen_enable_reg));
    wire curr_ok       = (cmd_current >= SSTAT_CURR_MIN) & (cmd_current <= SSTAT_CURR_MAX);
    // homing is a move command too, so it also clears the done flag
    wire done_clear    = cmd_move | cmd_home | cmd_preset | cmd_error_clear;
    wire done_set      = (motion_done & ~motion_homing) | cmd_param_range_err;

    // setup, command and input fault flags; set wins over clear
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            setup_fault_reg <= 1'b1;
            order_fault_reg <= 1'b0;
            input_fault_reg <= 1'b0;
        end else begin
            // a rejected configuration raises the fault again
            if (config_write)
                setup_fault_reg <= ~config_valid;

            // a bad command wins over an error clear in the same cycle
            if (cmd_invalid | cmd_param_range_err)
                order_fault_reg <= 1'b1;
            else if (cmd_error_clear)
                order_fault_reg <= 1'b0;

            if (input_set)
                input_fault_reg <= 1'b1;
            else if (cmd_error_clear)
                input_fault_reg <= 1'b0;
        end
    end

    // position trust and move completion
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            untrusted_reg    <= 1'b1;
            move_done_reg    <= 1'b0;
            origin_found_reg <= 1'b0;
        end else begin
            // a trust-losing event beats a preset arriving with it
            if (untrust_set)
                untrusted_reg <= 1'b1;
            else if (cmd_preset | home_done)
                untrusted_reg <= 1'b0;

            if (done_set)
                move_done_reg <= 1'b1;
            else if (done_clear)
                move_done_reg <= 1'b0;

            // a new homing run forgets the old origin until it completes
            if (home_done)
                origin_found_reg <= 1'b1;
            else if (cmd_move | cmd_home | config_write | untrust_set)
                origin_found_reg <= 1'b0;
        end
    end

    // drive side flags
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            limit_hit_reg    <= 1'b0;
            bad_param_reg    <= 1'b0;
            power_fault_reg  <= 1'b0;
            link_dropped_reg <= 1'b0;
            seen_enable_reg  <= 1'b0;
            limit_cw_d_reg   <= 1'b0;
            limit_ccw_d_reg  <= 1'b0;
        end else begin
            limit_cw_d_reg  <= limit_cw;
            limit_ccw_d_reg <= limit_ccw;
            // jumper absent at power up is not a fault until the driver was enabled clean
            if (driver_enable & ~drv_no_jumper)
                seen_enable_reg <= 1'b1;

            if (limit_set)
                limit_hit_reg <= 1'b1;
            else if (limit_release | cmd_error_clear)
                limit_hit_reg <= 1'b0;

            if (param_set)
                bad_param_reg <= 1'b1;
            else if (cmd_error_clear)
                bad_param_reg <= 1'b0;

            // the fault stays up while its cause lasts, even against a clear
            if (drv_fault_now)
                power_fault_reg <= 1'b1;
            else if (cmd_fault_clear)
                power_fault_reg <= 1'b0;

            if (link_restored)
                link_dropped_reg <= 1'b1;
            else if (cmd_error_clear)
                link_dropped_reg <= 1'b0;
        end
    end

    // current setting: out of range writes are dropped silently
    // no error is raised, so the host must read back the value in use
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n)
            current_reg <= SSTAT_CURR_RESET;
        else if (cmd_current_wr & curr_ok)
            current_reg <= cmd_current;
    end

    // heartbeat; counter held in configuration mode so the bit stops toggling
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            beat_cnt_reg <= 32'h0000_0000;
            alive_reg    <= 1'b0;
        end else if (!config_mode) begin
            if (beat_cnt_reg == 32'(SSTAT_BEAT_CYC - 1)) begin
                beat_cnt_reg <= 32'h0000_0000;
                alive_reg    <= ~alive_reg;
            end else begin
                beat_cnt_reg <= beat_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // coherent position sample: both halves taken in the same edge
    // a strobe between reads of the upper and lower word still mixes two samples
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            mpos_reg <= 32'h0000_0000;
            epos_reg <= 32'h0000_0000;
            cpos_reg <= 32'h0000_0000;
        end else if (sample_strobe) begin
            mpos_reg <= sstat_split(motor_pos);
            epos_reg <= sstat_split(encoder_pos);
            cpos_reg <= sstat_split(capture_pos);
        end
    end

    // lag compare; one turn of the rotor equals steps_per_turn
    // signed compare so a lag reported as negative never raises the flag
    wire lag_over  = hybrid_on & ($signed(lag_steps) > $signed(steps_per_turn));
    wire halted    = ~motion_moving;
    wire drive_on  = driver_enable & ~power_fault_reg
                     & ~(halted & idle_to_zero) & ~setup_fault_reg;

    // status word assembly
    wire [15:0] motion_word = {
        config_mode,
        controller_healthy,
        config_mode ? stall_detect_en : setup_fault_reg,
        order_fault_reg,
        input_fault_reg,
        untrusted_reg,
        segment_request,
        profile_load,
        move_done_reg,
        motion_decel & motion_moving,
        motion_accel & motion_moving,
        origin_found_reg,
        halted,
        motion_hold,
        motion_moving & motion_ccw,
        motion_moving & ~motion_ccw
    };
    // input state bits 2..0 are not carried here and read zero
    wire [15:0] drive_word = {
        drive_on,
        stall_seen,
        output_one_level,
        1'b0,
        alive_reg,
        limit_hit_reg,
        bad_param_reg,
        lag_over,
        power_fault_reg,
        link_dropped_reg,
        host_program_mode,
        2'b00,
        3'b000
    };

    // word mux for the input data image
    // indices past the last word read zero, so a stray poll is harmless
    logic [15:0] word_next;
    always_comb begin
        case (word_idx)
            SSTAT_IDX_MOTION:  word_next = motion_word;
            SSTAT_IDX_DRIVE:   word_next = drive_word;
            SSTAT_IDX_MPOS_HI: word_next = mpos_reg[31:16];
            SSTAT_IDX_MPOS_LO: word_next = mpos_reg[15:0];
            SSTAT_IDX_EPOS_HI: word_next = epos_reg[31:16];
            SSTAT_IDX_EPOS_LO: word_next = epos_reg[15:0];
            SSTAT_IDX_CPOS_HI: word_next = cpos_reg[31:16];
            SSTAT_IDX_CPOS_LO: word_next = cpos_reg[15:0];
            SSTAT_IDX_CURR:    word_next = current_reg;
            SSTAT_IDX_JERK:    word_next = jerk_value;
            default:           word_next = 16'h0000;
        endcase
    end

    // registered data output
    // one cycle of latency buys a glitch-free word for the host
    logic [15:0] word_reg;
    always_ff @(posedge core_clk or negedge rst_ok_n) begin
        if (!rst_ok_n)
            word_reg <= 16'h0000;
        else
            word_reg <= word_next;
    end

    assign word_data        = word_reg;
    assign abs_move_refused = cmd_move & cmd_absolute & untrusted_reg;
    assign motor_current_on = drive_on;
    assign current_in_use   = current_reg;
endmodule // sstat_status

//--- test/sstat_host_model.sv
// Purpose: host side model that polls the input words one at a time
// Assumes: word_data answers the index sampled at the previous edge
// Notes:   the index only moves just after an edge, never mid cycle
`timescale 1ns/1ps
module sstat_host_model
    import sstat_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic [15:0] word_data,
    output logic      [3:0]  word_idx
);
    initial word_idx = SSTAT_IDX_MOTION;

    // one word per cycle, taken at the edge after the index settles
    task automatic rd(input logic [3:0] i, output logic [15:0] d);
        word_idx = i;
        @(posedge core_clk);
        #1 d = word_data;
    endtask

    // the host keeps its next segment back until the device asks for it
    task automatic wait_seg(output logic ok);
        logic [15:0] d;
        ok = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            rd(SSTAT_IDX_MOTION, d);
            ok = d[9];
        end
    endtask
endmodule // sstat_host_model

//--- test/sstat_status_checker.sv
// Purpose: port level checks on the status word block
// Assumes: word_data is loaded at the edge that samples word_idx
// Notes:   level checks wait out the two-flop reset release
`timescale 1ns/1ps
module sstat_status_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        config_mode,
    input wire logic        cmd_invalid,
    input wire logic        cmd_param_range_err,
    input wire logic        cmd_error_clear,
    input wire logic        cmd_move,
    input wire logic        cmd_absolute,
    input wire logic        motion_moving,
    input wire logic        motion_accel,
    input wire logic        motion_decel,
    input wire logic        motion_ccw,
    input wire logic        stall_seen,
    input wire logic [3:0]  word_idx,
    input wire logic [15:0] word_data,
    input wire logic        abs_move_refused
);
    logic [1:0] up_reg;
    // the core is still in reset for two edges after rst_n rises
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    wire live = (up_reg == 2'h3);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // the checks tie flags and fixed zero bits of the answered word, and abs_move_refused, to their causes
    idx_range_a: assert property (word_idx > 4'h9 |=> word_data == 16'h0)
        else $error("unmapped word not zero");
    reserved_zero_a: assert property (word_idx == 4'h1 |=> word_data[12] == 1'b0
        && word_data[4:3] == 2'h0) else $error("reserved drive bits set");
    mode_bit_a: assert property ((live && word_idx == 4'h0 && config_mode)[*2]
        |=> word_data[15]) else $error("mode bit low in setup mode");
    order_set_a: assert property (live && cmd_invalid ##1 word_idx == 4'h0
        |=> word_data[12]) else $error("bad command not flagged");
    order_clear_a: assert property ((live && cmd_error_clear && !cmd_invalid
        && !cmd_param_range_err) ##1 word_idx == 4'h0 |=> !word_data[12])
        else $error("command fault survived clear");
    range_done_a: assert property (live && cmd_param_range_err ##1 word_idx == 4'h0
        |=> word_data[7] && word_data[12]) else $error("range error flags wrong");
    abs_refuse_a: assert property (abs_move_refused |-> cmd_move && cmd_absolute)
        else $error("refusal without absolute move");
    halted_a: assert property ((live && word_idx == 4'h0 && !motion_moving)[*2]
        |=> word_data[3]) else $error("halted flag low at rest");
    accel_flag_a: assert property ((live && word_idx == 4'h0 && motion_moving
        && motion_accel && !motion_decel)[*2] |=> word_data[5] && !word_data[6])
        else $error("speed phase flags wrong");
    turn_dir_a: assert property ((live && word_idx == 4'h0 && motion_moving
        && motion_ccw)[*2] |=> word_data[1] && !word_data[0])
        else $error("direction flags wrong");
    stall_bit_a: assert property ((live && word_idx == 4'h1 && stall_seen)[*2]
        |=> word_data[14]) else $error("stall not shown");
endmodule // sstat_status_checker

bind sstat_status sstat_status_checker u_chk (.*);

//--- test/test_stepper_status_reporting.sv
// Purpose: self-checking bench for the stepper status word block
// Assumes: the host model owns word_idx; the bench drives the rest
// Notes:   the heartbeat period is fixed and too long to watch here
`timescale 1ns/1ps
module test_stepper_status_reporting;
    import sstat_pkg::*;
    logic core_clk = 0, rst_n = 0, config_mode = 0, config_write = 0, config_valid = 0;
    logic stall_detect_en = 0, controller_healthy = 1, cmd_invalid = 0, cmd_move = 0;
    logic cmd_param_range_err = 0, cmd_absolute = 0, cmd_manual = 0, cmd_home = 0;
    logic cmd_manual_dir_ccw = 0, cmd_preset = 0, cmd_stop_now = 0, cmd_error_clear = 0;
    logic cmd_fault_clear = 0, cmd_current_wr = 0, motion_accel = 0, motion_decel = 0;
    logic motion_moving = 0, motion_hold = 0, motion_ccw = 0, motion_done = 0, home_done = 0;
    logic motion_homing = 0, segment_request = 0, profile_load = 0, estop_active = 0;
    logic limit_cw = 0, limit_ccw = 0, stall_seen = 0, output_one_level = 0, drv_short = 0;
    logic driver_enable = 0, idle_to_zero = 0, drv_over_temp = 0, drv_no_jumper = 0;
    logic manual_param_bad = 0, gear_active = 0, hybrid_on = 0, link_restored = 0;
    logic host_program_mode = 0, sample_strobe = 0, abs_move_refused, motor_current_on, k;
    logic [15:0] cmd_current = 16'h0, jerk_value = 16'h0123, word_data, current_in_use, v;
    logic [7:0]  gear_num = 8'h00, gear_den = 8'h01;
    logic [31:0] lag_steps = 32'h190, steps_per_turn = 32'hc8;
    logic signed [31:0] motor_pos = 0, encoder_pos = 0, capture_pos = 0;
    logic [3:0]  word_idx;
    int          err_total = 0, cmp_count = 0, cyc = 0;

    sstat_status u_dut (.*);
    sstat_host_model u_host (.core_clk, .word_data, .word_idx);

    always #10 core_clk = ~core_clk;
    // a hang is cut short well past the expected length of the run
    always @(posedge core_clk) if (++cyc > 4000) begin
        err_total++;
        complete_run;
    end

    task complete_run;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task bt(input logic [3:0] w, input int b, input logic e);
        u_host.rd(w, v);
        chk($sformatf("word %0d bit %0d", w, b), {15'h0, e}, {15'h0, v[b]});
    endtask
    task rw(input logic [3:0] w, input logic [15:0] e);
        u_host.rd(w, v);
        chk($sformatf("word %0d", w), e, v);
    endtask
    // events are one cycle wide, raised and dropped just after an edge
    task automatic pls(ref logic s);
        s = 1;
        @(posedge core_clk) #1 s = 0;
    endtask
    // first read lets the level settle into the flag registers
    task automatic lvl(ref logic s, input logic [3:0] w, input int b);
        s = 1;
        u_host.rd(w, v);
        bt(w, b, 1);
        s = 0;
    endtask
    task step;
        @(posedge core_clk) #1;
    endtask
    task amove(input logic e);
        cmd_move = 1;
        cmd_absolute = 1;
        #1 chk("abs refused", {15'h0, e}, {15'h0, abs_move_refused});
        @(posedge core_clk) #1 cmd_move = 0;
        cmd_absolute = 0;
    endtask

    task t_reset;
        bt(0, 13, 1);
        bt(0, 15, 0);
        bt(0, 10, 1);
        bt(1, 15, 0);
        rw(4'h8, 16'h000a);
        rw(4'h9, 16'h0123);
        rw(4'hc, 16'h0000);
        u_host.rd(4'h1, v);
        chk("reserved", 16'h0, v & 16'h1018);
    endtask
    task t_config;
        config_mode = 1;
        stall_detect_en = 1;
        step;
        bt(0, 15, 1);
        bt(0, 13, 1);
        config_valid = 1;
        pls(config_write);
        config_mode = 0;
        stall_detect_en = 0;
        step;
        bt(0, 15, 0);
        bt(0, 13, 0);
        bt(0, 10, 1);
    endtask
    task t_abs;
        amove(1);
        pls(cmd_preset);
        bt(0, 10, 0);
        amove(0);
        pls(cmd_stop_now);
        bt(0, 10, 1);
    endtask
    task t_order;
        pls(cmd_invalid);
        bt(0, 12, 1);
        bt(0, 7, 0);
        pls(cmd_error_clear);
        bt(0, 12, 0);
        pls(cmd_param_range_err);
        bt(0, 7, 1);
        pls(cmd_error_clear);
        bt(0, 7, 0);
    endtask
    // edges of the 1.0 to 6.0 amp window, out of range values change nothing
    task automatic t_current;
        logic [15:0] wv [4] = '{16'h003e, 16'h0009, 16'h003c, 16'h000a};
        logic [15:0] ev [4] = '{16'h000a, 16'h000a, 16'h003c, 16'h000a};
        for (int i = 0; i < 4; i++) begin
            cmd_current = wv[i];
            pls(cmd_current_wr);
            rw(4'h8, ev[i]);
        end
        chk("in use", 16'h000a, current_in_use);
        bt(0, 12, 0);
    endtask
    task t_move;
        motion_moving = 1;
        motion_accel = 1;
        motion_ccw = 1;
        pls(cmd_move);
        bt(0, 5, 1);
        bt(0, 3, 0);
        bt(0, 1, 1);
        motion_accel = 0;
        motion_decel = 1;
        step;
        bt(0, 6, 1);
        motion_decel = 0;
        motion_moving = 0;
        motion_ccw = 0;
        pls(motion_done);
        bt(0, 7, 1);
        bt(0, 3, 1);
        pls(cmd_home);
        motion_homing = 1;
        motion_done = 1;
        pls(home_done);
        motion_done = 0;
        motion_homing = 0;
        bt(0, 4, 1);
        bt(0, 7, 0);
    endtask
    task t_fault;
        lvl(estop_active, 4'h0, 11);
        pls(cmd_error_clear);
        bt(0, 11, 0);
        limit_ccw = 1;
        cmd_manual_dir_ccw = 1;
        pls(cmd_manual);
        bt(0, 11, 1);
        limit_ccw = 0;
        motion_moving = 1;
        lvl(limit_cw, 4'h1, 10);
        bt(0, 10, 1);
        step;
        bt(1, 10, 0);
        motion_moving = 0;
        pls(cmd_error_clear);
        pls(link_restored);
        bt(1, 6, 1);
        bt(0, 11, 1);
    endtask
    // the sample is taken once; a later move of motor_pos must not tear it
    task automatic t_pos;
        logic [15:0] ev [6] = '{16'hfb2e, 16'hfdc9, 16'h07d0, 16'h0001, 16'hffff, 16'hffff};
        motor_pos = -32'sd1234567;
        encoder_pos = 32'sd2000001;
        capture_pos = -32'sd1001;
        pls(sample_strobe);
        motor_pos = 32'sd5;
        for (int i = 0; i < 6; i++) rw(4'(i + 2), ev[i]);
    endtask
    task t_drive;
        driver_enable = 1;
        step;
        bt(1, 15, 1);
        idle_to_zero = 1;
        step;
        bt(1, 15, 0);
        idle_to_zero = 0;
        estop_active = 1;
        step;
        bt(1, 15, 1);
        estop_active = 0;
        lvl(drv_over_temp, 4'h1, 7);
        bt(1, 15, 0);
        chk("current on", 16'h0, {15'h0, motor_current_on});
        pls(cmd_fault_clear);
        bt(1, 7, 0);
        lvl(drv_short, 4'h1, 7);
    endtask
    task t_misc;
        lvl(stall_seen, 4'h1, 14);
        lvl(output_one_level, 4'h1, 13);
        lvl(host_program_mode, 4'h1, 5);
        lvl(motion_hold, 4'h0, 2);
        lvl(profile_load, 4'h0, 8);
        lvl(hybrid_on, 4'h1, 8);
        lvl(gear_active, 4'h1, 9);
        segment_request = 1;
        u_host.wait_seg(k);
        chk("segment ready", 16'h1, {15'h0, k});
    endtask

    // reset held for eight cycles, then one spare edge past the release flops
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1;
        repeat (3) step;
        t_reset;
        t_config;
        t_abs;
        t_order;
        t_current;
        t_move;
        t_fault;
        t_pos;
        t_drive;
        t_misc;
        complete_run;
    end
endmodule // test_stepper_status_reporting
